// File: awc_map.svh
// Offsets, field positions, reset values and timing figures of the alarm watch
`ifndef AWC_MAP_SVH
`define AWC_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// Time base and timing figures
`define AWC_XTAL_HZ        32768
`define AWC_DEBOUNCE_US    62500
`define AWC_VIEW_SEC       3
`define AWC_RING_SEC       60
`define AWC_SNOOZE_MIN     5

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define AWC_REG_TIME       5'h00
`define AWC_REG_DATE       5'h04
`define AWC_REG_ALARM      5'h08
`define AWC_REG_CTRL       5'h0c

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define AWC_F_SEC          0
`define AWC_F_MIN          8
`define AWC_F_HR           16
`define AWC_F_PM           20
`define AWC_F_MON          0
`define AWC_F_DATE         8
`define AWC_F_ARMED        24
`define AWC_F_ALST         25
`define AWC_F_MUTE         0

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define AWC_RST_HR         4'hc
`define AWC_RST_MON        4'h1
`define AWC_RST_DATE       5'h01
`define AWC_RST_MUTE       1'b0

`endif

// File: awc_pkg.sv
// Types shared by the alarm watch controller
`default_nettype none

package awc_pkg;

	typedef enum logic [3:0] {
		AWC_V_TIME  = 4'h0,
		AWC_V_DATE  = 4'h1,
		AWC_V_SECS  = 4'h2,
		AWC_V_ALARM = 4'h3,
		AWC_S_AHR   = 4'h4,
		AWC_S_AMIN  = 4'h5,
		AWC_S_MON   = 4'h6,
		AWC_S_DATE  = 4'h7,
		AWC_S_HR    = 4'h8,
		AWC_S_MIN   = 4'h9
	} awc_view_t;

	typedef enum logic [1:0] {
		AWC_AL_IDLE   = 2'h0,
		AWC_AL_RING   = 2'h1,
		AWC_AL_SNOOZE = 2'h2
	} awc_al_t;

	typedef struct packed {
		awc_view_t  view;
		logic [3:0] hi;
		logic [5:0] lo;
		logic       hi_on;
		logic       lo_on;
		logic       ampm_ind;
		logic       pm;
	} awc_disp_t;

endpackage

`default_nettype wire

// File: awc_watch.sv
// Alarm watch controller: time base, buttons, views, setting, alarm, register slave
//
// The register addresses and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`include "awc_map.svh"
`default_nettype none

module awc_watch #(
	parameter int unsigned XTAL_HZ = `AWC_XTAL_HZ
) (
	input  wire logic              i_clk_sys,
	input  wire logic              i_sys_rst,
	input  wire logic              i_xtal,
	input  wire logic              i_display_button,
	input  wire logic              i_set_button,
	input  wire logic              i_wb_cyc,
	input  wire logic              i_wb_stb,
	input  wire logic              i_wb_we,
	input  wire logic [4:0]        i_wb_adr,
	input  wire logic [3:0]        i_wb_sel,
	input  wire logic [31:0]       i_wb_dat,
	output logic      [31:0]       o_wb_dat,
	output logic                   o_wb_ack,
	output awc_pkg::awc_disp_t     o_disp,
	output logic                   o_alarm,
	output logic                   o_alarm_flag
);

	localparam int unsigned DB_RAW  = 32'((64'(`AWC_DEBOUNCE_US) * 64'(XTAL_HZ)) / 64'd1000000);
	localparam logic [15:0] DB_M1   = 16'((DB_RAW == 0) ? 0 : DB_RAW - 1);
	localparam logic [15:0] DIV_M1  = 16'(XTAL_HZ - 1);
	localparam logic [15:0] HALF    = 16'(XTAL_HZ / 2);
	localparam logic [15:0] QUART   = 16'(XTAL_HZ / 4);
	localparam logic [15:0] HALF_M1 = 16'(XTAL_HZ / 2 - 1);
	localparam logic [17:0] T3_M1   = 18'(`AWC_VIEW_SEC * XTAL_HZ - 1);
	localparam logic [8:0]  RING_M1 = 9'(`AWC_RING_SEC - 1);
	localparam logic [8:0]  SNZ_M1  = 9'(`AWC_SNOOZE_MIN * 60 - 1);

	function automatic logic [4:0] days_in(input logic [3:0] m);
		case (m)
			4'h2: days_in = 5'd28;
			4'h4, 4'h6, 4'h9, 4'hb: days_in = 5'd30;
			default: days_in = 5'd31;
		endcase
	endfunction

	// Returns {pm, hour}; PM flips on the 11 to 12 step
	function automatic logic [4:0] hour_up(input logic p, input logic [3:0] h);
		hour_up = {(h == 4'hb) ? ~p : p, (h == 4'hc) ? 4'h1 : h + 4'h1};
	endfunction

	function automatic logic [5:0] min_up(input logic [5:0] m);
		min_up = (m == 6'd59) ? 6'd0 : m + 6'd1;
	endfunction

	function automatic logic is_set(input awc_pkg::awc_view_t v);
		is_set = (v >= awc_pkg::AWC_S_AHR);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Crystal edge and binary divider
	logic [2:0]  xt_s;
	logic        xt;
	logic [15:0] div;
	logic        sec_tick;
	logic        half_phase;
	logic        beep_2hz;
	logic        sec_hold;

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			xt_s <= 3'h0;
		end else begin
			xt_s <= {xt_s[1:0], i_xtal};
		end
	end

	assign xt = xt_s[1] & ~xt_s[2];

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst || sec_hold) begin
			div <= 16'h0;
		end else if (xt) begin
			div <= (div == DIV_M1) ? 16'h0 : div + 16'h1;
		end
	end

	assign sec_tick   = xt && div == DIV_M1 && !sec_hold;
	assign half_phase = div < HALF;
	assign beep_2hz   = ((div >= HALF) ? div - HALF : div) < QUART;

	////////////////////////////////////////////////////////////////////////////
	// Button synchronisers and debounce, index 0 display, 1 set
	logic [1:0]  btn_in;
	logic [1:0]  btn_s1;
	logic [1:0]  btn_s2;
	logic [1:0]  db;
	logic [1:0]  db_q;
	logic [15:0] db_cnt [2];
	logic        d_press;
	logic        s_press;
	logic        dh;
	logic        dp;

	assign btn_in = {i_set_button, i_display_button};

	generate
		for (genvar g = 0; g < 2; g++) begin : g_btn
			always_ff @(posedge i_clk_sys) begin
				if (i_sys_rst) begin
					btn_s1[g]  <= 1'b0;
					btn_s2[g]  <= 1'b0;
					db[g]      <= 1'b0;
					db_q[g]    <= 1'b0;
					db_cnt[g]  <= 16'h0;
				end else begin
					btn_s1[g] <= btn_in[g];
					btn_s2[g] <= btn_s1[g];
					db_q[g]   <= db[g];
					if (btn_s2[g] == db[g]) begin
						db_cnt[g] <= 16'h0;
					end else if (xt) begin
						if (db_cnt[g] == DB_M1) begin
							db[g]     <= btn_s2[g];
							db_cnt[g] <= 16'h0;
						end else begin
							db_cnt[g] <= db_cnt[g] + 16'h1;
						end
					end
				end
			end
		end
	endgenerate

	assign d_press = db[0] & ~db_q[0];
	assign s_press = db[1] & ~db_q[1];
	assign dh      = db[0];

	////////////////////////////////////////////////////////////////////////////
	// Registers of time, alarm and control
	awc_pkg::awc_view_t view;
	awc_pkg::awc_view_t next_view;
	awc_pkg::awc_al_t   al_state;
	logic [5:0]  sec;
	logic [5:0]  min;
	logic [3:0]  hr;
	logic        pm;
	logic [3:0]  mon;
	logic [4:0]  date;
	logic [5:0]  a_min;
	logic [3:0]  a_hr;
	logic        a_pm;
	logic        armed;
	logic        mute;
	logic        min_chk;
	logic        adv;
	logic [15:0] rep_tmr;
	logic [17:0] view_tmr;
	logic        tmo;
	logic        tmr_clr;

	// Held display button repeats every half second in set states
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst || d_press || !dh) begin
			rep_tmr <= 16'h0;
		end else if (xt) begin
			rep_tmr <= (rep_tmr == HALF_M1) ? 16'h0 : rep_tmr + 16'h1;
		end
	end

	assign adv = is_set(view) && (d_press || (dh && xt && rep_tmr == HALF_M1));

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			sec  <= 6'd0;
			min  <= 6'd0;
			hr   <= `AWC_RST_HR;
			pm   <= 1'b0;
			mon  <= `AWC_RST_MON;
			date <= `AWC_RST_DATE;
		end else if (adv) begin
			case (view)
				awc_pkg::AWC_S_MON: begin
					mon  <= (mon == 4'hc) ? 4'h1 : mon + 4'h1;
					date <= 5'd1;
				end
				awc_pkg::AWC_S_DATE: date <= (date == days_in(mon)) ? 5'd1 : date + 5'd1;
				awc_pkg::AWC_S_HR: {pm, hr} <= hour_up(pm, hr);
				awc_pkg::AWC_S_MIN: begin
					min <= min_up(min);
					sec <= 6'd0;
				end
				default: begin
				end
			endcase
		end else if (sec_tick) begin
			sec <= (sec == 6'd59) ? 6'd0 : sec + 6'd1;
			if (sec == 6'd59) begin
				min <= min_up(min);
				if (min == 6'd59) begin
					{pm, hr} <= hour_up(pm, hr);
					if (pm && hr == 4'hb) begin
						date <= (date == days_in(mon)) ? 5'd1 : date + 5'd1;
						if (date == days_in(mon)) begin
							mon <= (mon == 4'hc) ? 4'h1 : mon + 4'h1;
						end
					end
				end
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			sec_hold <= 1'b0;
		end else if (view == awc_pkg::AWC_S_MIN && adv) begin
			sec_hold <= 1'b1;
		end else if (view != awc_pkg::AWC_S_MIN) begin
			sec_hold <= 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			a_min <= 6'd0;
			a_hr  <= `AWC_RST_HR;
			a_pm  <= 1'b0;
		end else if (adv && view == awc_pkg::AWC_S_AHR) begin
			{a_pm, a_hr} <= hour_up(a_pm, a_hr);
		end else if (adv && view == awc_pkg::AWC_S_AMIN) begin
			a_min <= min_up(a_min);
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			armed <= 1'b0;
		end else if (view == awc_pkg::AWC_V_ALARM && dp) begin
			armed <= ~armed;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// View and setting state machine
	assign dp  = d_press && al_state == awc_pkg::AWC_AL_IDLE;
	assign tmo = xt && view_tmr == T3_M1;

	always_comb begin
		next_view = view;
		case (view)
			awc_pkg::AWC_V_TIME: begin
				if (dp) begin
					next_view = awc_pkg::AWC_V_DATE;
				end else if (s_press) begin
					next_view = awc_pkg::AWC_S_AHR;
				end
			end
			awc_pkg::AWC_V_DATE: begin
				if (dp) begin
					next_view = awc_pkg::AWC_V_ALARM;
				end else if (tmo) begin
					next_view = dh ? awc_pkg::AWC_V_SECS : awc_pkg::AWC_V_TIME;
				end
			end
			awc_pkg::AWC_V_SECS: if (dp) next_view = awc_pkg::AWC_V_TIME;
			awc_pkg::AWC_V_ALARM: if (tmo) next_view = awc_pkg::AWC_V_TIME;
			awc_pkg::AWC_S_AHR: begin
				if (s_press) begin
					next_view = awc_pkg::AWC_S_AMIN;
				end else if (tmo) begin
					next_view = awc_pkg::AWC_V_TIME;
				end
			end
			awc_pkg::AWC_S_AMIN: begin
				if (s_press) begin
					next_view = awc_pkg::AWC_S_MON;
				end else if (tmo) begin
					next_view = awc_pkg::AWC_V_TIME;
				end
			end
			awc_pkg::AWC_S_MON: if (s_press) next_view = awc_pkg::AWC_S_DATE;
			awc_pkg::AWC_S_DATE: if (s_press) next_view = awc_pkg::AWC_S_HR;
			awc_pkg::AWC_S_HR: if (s_press) next_view = awc_pkg::AWC_S_MIN;
			awc_pkg::AWC_S_MIN: if (s_press) next_view = awc_pkg::AWC_V_TIME;
			default: next_view = awc_pkg::AWC_V_TIME;
		endcase
	end

	assign tmr_clr = (next_view != view) || dp || s_press || (is_set(view) && dh);

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			view     <= awc_pkg::AWC_V_TIME;
			view_tmr <= 18'h0;
		end else begin
			view <= next_view;
			if (tmr_clr) begin
				view_tmr <= 18'h0;
			end else if (xt && view_tmr != T3_M1) begin
				view_tmr <= view_tmr + 18'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Alarm ring, snooze and cancel
	logic [8:0]  al_sec;
	logic        pend;
	logic [17:0] win;
	logic        match;

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			min_chk <= 1'b0;
		end else begin
			min_chk <= sec_tick && sec == 6'd59;
		end
	end

	assign match = armed && hr == a_hr && min == a_min && pm == a_pm;

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			al_state <= awc_pkg::AWC_AL_IDLE;
			al_sec   <= 9'h0;
			pend     <= 1'b0;
			win      <= 18'h0;
		end else begin
			if (pend && xt) begin
				win <= win + 18'h1;
				if (win == T3_M1) begin
					pend <= 1'b0;
				end
			end
			case (al_state)
				awc_pkg::AWC_AL_IDLE: begin
					pend <= 1'b0;
					if (min_chk && match) begin
						al_state <= awc_pkg::AWC_AL_RING;
						al_sec   <= 9'h0;
					end
				end
				awc_pkg::AWC_AL_RING: begin
					if (d_press) begin
						al_state <= awc_pkg::AWC_AL_SNOOZE;
						al_sec   <= 9'h0;
						pend     <= 1'b1;
						win      <= 18'h0;
					end else if (sec_tick) begin
						al_sec <= al_sec + 9'h1;
						if (al_sec == RING_M1) begin
							al_state <= awc_pkg::AWC_AL_IDLE;
						end
					end
				end
				awc_pkg::AWC_AL_SNOOZE: begin
					if (d_press && pend) begin
						al_state <= awc_pkg::AWC_AL_IDLE;
					end else if (d_press) begin
						pend <= 1'b1;
						win  <= 18'h0;
					end else if (sec_tick) begin
						al_sec <= al_sec + 9'h1;
						if (al_sec == SNZ_M1) begin
							al_state <= awc_pkg::AWC_AL_RING;
							al_sec   <= 9'h0;
						end
					end
				end
				default: al_state <= awc_pkg::AWC_AL_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs to display and transducer
	awc_pkg::awc_disp_t next_disp;

	always_comb begin
		next_disp          = '0;
		next_disp.view     = view;
		next_disp.hi       = hr;
		next_disp.lo       = min;
		next_disp.hi_on    = 1'b1;
		next_disp.lo_on    = 1'b1;
		next_disp.pm       = pm;
		case (view)
			awc_pkg::AWC_V_DATE, awc_pkg::AWC_S_MON, awc_pkg::AWC_S_DATE: begin
				next_disp.hi = mon;
				next_disp.lo = {1'b0, date};
			end
			awc_pkg::AWC_V_SECS: begin
				next_disp.hi_on = 1'b0;
				next_disp.lo    = sec;
			end
			awc_pkg::AWC_V_ALARM, awc_pkg::AWC_S_AMIN, awc_pkg::AWC_S_AHR: begin
				next_disp.hi = a_hr;
				next_disp.lo = a_min;
				next_disp.pm = a_pm;
			end
			default: begin
			end
		endcase
		case (view)
			awc_pkg::AWC_S_AHR: begin
				next_disp.hi_on    = half_phase;
				next_disp.lo_on    = 1'b0;
				next_disp.ampm_ind = 1'b1;
			end
			awc_pkg::AWC_S_HR: begin
				next_disp.hi_on    = half_phase;
				next_disp.lo_on    = 1'b0;
				next_disp.ampm_ind = 1'b1;
			end
			awc_pkg::AWC_S_MON: next_disp.hi_on = half_phase;
			awc_pkg::AWC_S_AMIN, awc_pkg::AWC_S_DATE, awc_pkg::AWC_S_MIN: next_disp.lo_on = half_phase;
			default: begin
			end
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_disp       <= '0;
			o_alarm      <= 1'b0;
			o_alarm_flag <= 1'b0;
		end else begin
			o_disp       <= next_disp;
			o_alarm_flag <= armed;
			o_alarm      <= !mute && ((al_state == awc_pkg::AWC_AL_RING && half_phase) ||
				(view == awc_pkg::AWC_V_ALARM && armed && dh && beep_2hz));
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Wishbone classic slave
	logic [31:0] rd;

	always_comb begin
		rd = 32'h0;
		case (i_wb_adr)
			`AWC_REG_TIME: begin
				rd[`AWC_F_SEC +: 6] = sec;
				rd[`AWC_F_MIN +: 6] = min;
				rd[`AWC_F_HR +: 4]  = hr;
				rd[`AWC_F_PM]       = pm;
			end
			`AWC_REG_DATE: begin
				rd[`AWC_F_MON +: 4]  = mon;
				rd[`AWC_F_DATE +: 5] = date;
			end
			`AWC_REG_ALARM: begin
				rd[`AWC_F_MIN +: 6]  = a_min;
				rd[`AWC_F_HR +: 4]   = a_hr;
				rd[`AWC_F_PM]        = a_pm;
				rd[`AWC_F_ARMED]     = armed;
				rd[`AWC_F_ALST +: 2] = al_state;
			end
			`AWC_REG_CTRL: rd[`AWC_F_MUTE] = mute;
			default: rd = 32'h0;
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0;
			mute     <= `AWC_RST_MUTE;
		end else begin
			o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
			if (i_wb_cyc && i_wb_stb && !o_wb_ack) begin
				o_wb_dat <= rd;
				if (i_wb_we && i_wb_sel[0] && i_wb_adr == `AWC_REG_CTRL) begin
					mute <= i_wb_dat[`AWC_F_MUTE];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);

	sequence s_date_quiet;
		view == awc_pkg::AWC_V_DATE && tmo && !dp && !dh;
	endsequence
	sequence s_date_held;
		view == awc_pkg::AWC_V_DATE && tmo && !dp && dh;
	endsequence
	sequence s_second_press;
		al_state == awc_pkg::AWC_AL_SNOOZE && pend ##0 d_press;
	endsequence

	chk_date_return: assert property (s_date_quiet |=> view == awc_pkg::AWC_V_TIME)
		else $error("date view did not return to time");
	chk_seconds_view: assert property (s_date_held |=> view == awc_pkg::AWC_V_SECS)
		else $error("held button did not reach seconds view");
	chk_alarm_view: assert property (view == awc_pkg::AWC_V_DATE && dp |=> view == awc_pkg::AWC_V_ALARM)
		else $error("second press did not show alarm time");
	chk_arm_toggle: assert property (view == awc_pkg::AWC_V_ALARM && dp |=> ##1 o_alarm_flag != $past(o_alarm_flag, 2))
		else $error("third press did not toggle arm flag");
	chk_ring_start: assert property (al_state == awc_pkg::AWC_AL_IDLE && min_chk && match
		|=> al_state == awc_pkg::AWC_AL_RING)
		else $error("alarm match did not start ring");
	chk_ring_beep: assert property (al_state == awc_pkg::AWC_AL_RING && half_phase && !mute |=> o_alarm)
		else $error("ringing alarm is silent");
	chk_snooze_quiet: assert property (al_state == awc_pkg::AWC_AL_SNOOZE && view != awc_pkg::AWC_V_ALARM
		|=> !o_alarm)
		else $error("alarm sounds during snooze");
	chk_cancel_event: assert property (s_second_press |=> al_state == awc_pkg::AWC_AL_IDLE)
		else $error("double press did not cancel alarm");
	chk_set_timeout: assert property (view == awc_pkg::AWC_S_AHR && tmo && !s_press && !dp && !dh
		|=> view == awc_pkg::AWC_V_TIME)
		else $error("alarm hour setting did not time out");
	chk_month_stays: assert property (view == awc_pkg::AWC_S_MON && !s_press |=> view == awc_pkg::AWC_S_MON)
		else $error("month setting left without set press");
	chk_seconds_hold: assert property (sec_hold |=> sec == 6'd0 && div == 16'h0 && !sec_tick)
		else $error("seconds run while held");

endmodule // awc_watch

`default_nettype wire

// File: awc_partner.sv
// Push-button switches and crystal feeding the alarm watch controller
`timescale 1ns/1ps
`default_nettype none

module awc_partner (
	input  wire logic i_clk_sys,
	output logic      o_xtal,
	output logic      o_display_button,
	output logic      o_set_button
);
	int unsigned xdiv;

	initial begin
		o_xtal = 1'b0;
		o_display_button = 1'b0;
		o_set_button = 1'b0;
		xdiv = 0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Crystal edge every third system clock, free running
	always @(posedge i_clk_sys) begin
		xdiv = (xdiv == 2) ? 0 : xdiv + 1;
		if (xdiv == 0)
			o_xtal <= ~o_xtal;
	end

	////////////////////////////////////////////////////////////////////////////
	// Contact bounce around a held press; released pin falls to its pull-down
	task automatic drv(input bit set, input logic v);
		if (set)
			o_set_button <= v;
		else
			o_display_button <= v;
	endtask

	task automatic press(input bit set, input int hold);
		int n;
		n = 2 * $urandom_range(3, 1) + 1;
		for (int k = 0; k < n; k++) begin
			@(posedge i_clk_sys);
			drv(set, k[0] == 1'b0);
		end
		repeat (hold) @(posedge i_clk_sys);
		for (int k = 0; k < n; k++) begin
			@(posedge i_clk_sys);
			drv(set, k[0] == 1'b1);
		end
		repeat (80) @(posedge i_clk_sys);
	endtask
endmodule // awc_partner

`default_nettype wire

// File: alarm_watch_controller_tb.sv
// Self-checking bench of the alarm watch controller
`timescale 1ns/1ps
`default_nettype none

module alarm_watch_controller_tb;
	localparam int SEC = 384;
	logic               i_clk_sys, i_sys_rst, i_xtal, i_display_button, i_set_button;
	logic               i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack, o_alarm, o_alarm_flag;
	logic [4:0]         i_wb_adr;
	logic [3:0]         i_wb_sel;
	logic [31:0]        i_wb_dat, o_wb_dat, rd;
	awc_pkg::awc_disp_t o_disp;
	int                 mismatches, cmp_count, exp_amin, exp_armed, k, c;

	awc_watch #(.XTAL_HZ(64)) uut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_xtal(i_xtal),
		.i_display_button(i_display_button), .i_set_button(i_set_button), .i_wb_cyc(i_wb_cyc),
		.i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
		.i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_disp(o_disp),
		.o_alarm(o_alarm), .o_alarm_flag(o_alarm_flag));

	awc_partner ptn (.i_clk_sys(i_clk_sys), .o_xtal(i_xtal), .o_display_button(i_display_button),
		.o_set_button(i_set_button));

	initial begin
		i_clk_sys = 1'b0;
		forever #50 i_clk_sys = ~i_clk_sys;
	end

	////////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic view(input awc_pkg::awc_view_t v);
		check({28'h0, o_disp.view}, {28'h0, v}, "view");
	endtask

	task automatic wb(input logic we, input logic [4:0] adr, input logic [31:0] dat);
		int n;
		n = 0;
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we <= we;
		i_wb_adr <= adr;
		i_wb_dat <= dat;
		do begin
			@(posedge i_clk_sys);
			n++;
		end while (o_wb_ack !== 1'b1 && n < 20);
		rd = o_wb_dat;
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
		i_wb_we <= 1'b0;
		if (n >= 20) begin
			check(0, 1, "bus timeout");
			give_verdict();
		end
		@(posedge i_clk_sys);
	endtask

	task automatic secs(input int tenths);
		repeat (tenths * SEC / 10) @(posedge i_clk_sys);
	endtask

	task automatic beeps(input int tenths, output int cnt);
		logic prev;
		cnt = 0;
		prev = o_alarm;
		repeat (tenths * SEC / 10) begin
			@(posedge i_clk_sys);
			if (o_alarm === 1'b1 && prev !== 1'b1)
				cnt++;
			prev = o_alarm;
		end
	endtask

	function automatic logic [31:0] alarm_word(input int st);
		return 32'((st << 25) | (exp_armed << 24) | (12 << 16) | (exp_amin << 8));
	endfunction

	initial begin
		repeat (100000) @(posedge i_clk_sys);
		check(0, 1, "run timeout");
		give_verdict();
	end

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		i_sys_rst = 1'b1;
		i_wb_cyc = 1'b0;
		i_wb_stb = 1'b0;
		i_wb_we = 1'b0;
		i_wb_adr = 5'h00;
		i_wb_sel = 4'hf;
		i_wb_dat = 32'h0;
		mismatches = 0;
		cmp_count = 0;
		exp_amin = 0;
		exp_armed = 0;
		void'($urandom(32'h471e));
		repeat (2) @(posedge i_clk_sys);
		i_sys_rst <= 1'b0;
		@(posedge i_clk_sys);
		@(posedge i_clk_sys);
		view(awc_pkg::AWC_V_TIME);
		wb(0, 5'h00, 0);
		check(rd, 32'h000c0000, "time");
		wb(0, 5'h04, 0);
		check(rd, 32'h00000101, "date");
		wb(0, 5'h08, 0);
		check(rd, alarm_word(0), "alarm");
		wb(0, 5'h14, 0);
		check(rd, 32'h0, "unmapped");
		wb(1, 5'h0c, 32'h1);
		wb(0, 5'h0c, 0);
		check(rd, 32'h1, "mute");
		wb(1, 5'h0c, 32'h0);
		// One press shows the date, then time returns
		ptn.press(0, 60);
		view(awc_pkg::AWC_V_DATE);
		secs(20);
		view(awc_pkg::AWC_V_DATE);
		secs(15);
		view(awc_pkg::AWC_V_TIME);
		// Long hold gives seconds
		ptn.press(0, 1344);
		view(awc_pkg::AWC_V_SECS);
		ptn.press(0, 60);
		view(awc_pkg::AWC_V_TIME);
		secs(35);
		// Alarm minute setting and its timeout
		ptn.press(1, 60);
		view(awc_pkg::AWC_S_AHR);
		check({31'h0, o_disp.ampm_ind}, 1, "a/p");
		ptn.press(1, 60);
		view(awc_pkg::AWC_S_AMIN);
		ptn.press(0, 60);
		exp_amin = 1;
		check({26'h0, o_disp.lo}, 32'(exp_amin), "alarm min");
		secs(20);
		view(awc_pkg::AWC_S_AMIN);
		secs(15);
		view(awc_pkg::AWC_V_TIME);
		// Alarm hour setting left alone times out
		ptn.press(1, 60);
		view(awc_pkg::AWC_S_AHR);
		secs(35);
		view(awc_pkg::AWC_V_TIME);
		// Arm through the triple press, held so the armed view beeps
		ptn.press(0, 60);
		ptn.press(0, 60);
		view(awc_pkg::AWC_V_ALARM);
		check({28'h0, o_disp.hi}, 32'hc, "alarm hr");
		fork
			ptn.press(0, 400);
			beeps(8, c);
		join
		exp_armed = 1;
		check({31'h0, o_alarm_flag}, 1, "flag");
		check(32'(c > 0), 1, "held beep");
		wb(0, 5'h08, 0);
		check(rd, alarm_word(0), "armed");
		secs(35);
		// Ring at the minute match
		k = 0;
		do begin
			wb(0, 5'h08, 0);
			repeat (36) @(posedge i_clk_sys);
			k++;
		end while (rd[26:25] !== 2'h1 && k < 800);
		check(rd, alarm_word(1), "ring");
		wb(0, 5'h00, 0);
		check({19'h0, rd[20:8]}, 32'h00000c01, "match time");
		beeps(40, c);
		check(32'(c >= 3 && c <= 5), 1, "1 Hz beeps");
		wb(1, 5'h0c, 32'h1);
		beeps(20, c);
		check(32'(c), 0, "muted");
		wb(1, 5'h0c, 32'h0);
		// Snooze, then cancel
		ptn.press(0, 60);
		wb(0, 5'h08, 0);
		check(rd, alarm_word(2), "snooze");
		beeps(20, c);
		check(32'(c), 0, "snooze quiet");
		secs(35);
		ptn.press(0, 60);
		ptn.press(0, 60);
		wb(0, 5'h08, 0);
		check(rd, alarm_word(0), "cancel");
		view(awc_pkg::AWC_V_TIME);
		secs(35);
		// Time setting chain
		for (k = 0; k < 3; k++)
			ptn.press(1, 60);
		secs(40);
		view(awc_pkg::AWC_S_MON);
		ptn.press(0, 400);
		check({28'h0, o_disp.hi}, 32'h4, "held month");
		ptn.press(1, 60);
		view(awc_pkg::AWC_S_DATE);
		ptn.press(0, 60);
		check({26'h0, o_disp.lo}, 32'h2, "date adv");
		ptn.press(1, 60);
		view(awc_pkg::AWC_S_HR);
		check({31'h0, o_disp.ampm_ind}, 1, "hr a/p");
		ptn.press(1, 60);
		view(awc_pkg::AWC_S_MIN);
		ptn.press(0, 60);
		secs(15);
		wb(0, 5'h00, 0);
		check({26'h0, rd[5:0]}, 0, "sec held");
		ptn.press(1, 60);
		view(awc_pkg::AWC_V_TIME);
		secs(15);
		wb(0, 5'h00, 0);
		check(32'(rd[5:0] != 6'h0), 1, "sec runs");
		give_verdict();
	end
endmodule // alarm_watch_controller_tb

`default_nettype wire
